// ==== core/bram_monitor.sv ====
// Boot remap and abort monitor top: bus slave, abort capture, interrupt pass-through
`timescale 1ns/1ps

module bram_monitor (
   input  wire logic         aclk,               // System clock, 40 MHz
   input  wire logic         aresetn,            // Synchronous reset, active low
   // AXI4-Lite slave
   input  wire logic [7:0]   s_axi_awaddr,       // Write address
   input  wire logic         s_axi_awvalid,      // Write address valid
   output logic              s_axi_awready,      // Write address ready
   input  wire logic [31:0]  s_axi_wdata,        // Write data
   input  wire logic [3:0]   s_axi_wstrb,        // Write byte strobes
   input  wire logic         s_axi_wvalid,       // Write data valid
   output logic              s_axi_wready,       // Write data ready
   output logic [1:0]        s_axi_bresp,        // Write response
   output logic              s_axi_bvalid,       // Write response valid
   input  wire logic         s_axi_bready,       // Write response ready
   input  wire logic [7:0]   s_axi_araddr,       // Read address
   input  wire logic         s_axi_arvalid,      // Read address valid
   output logic              s_axi_arready,      // Read address ready
   output logic [31:0]       s_axi_rdata,        // Read data
   output logic [1:0]        s_axi_rresp,        // Read response
   output logic              s_axi_rvalid,       // Read data valid
   input  wire logic         s_axi_rready,       // Read data ready
   // Masters
   input  bram_pkg::bram_req_t mst_req,          // Request of the granted master
   input  wire logic [3:0]   mst_grant,          // One-hot current master, bit 0 cpu
   output logic [3:0]        mst_abort,          // Abort broadcast, same on every bit
   output bram_pkg::bram_decode_t dec_out,       // Decode answer to memory slaves
   output logic              vector_access,      // Access falls on exception vectors
   // Pins and interrupts
   input  wire logic         boot_source_select, // Boot-select pin
   input  wire logic         ebi_refresh_irq,    // Refresh-error interrupt in
   input  wire logic         system_timer_irq,   // Timer interrupt line
   input  wire logic         debug_serial_irq,   // Debug serial interrupt line
   input  wire logic         power_manager_irq,  // Power manager interrupt line
   input  wire logic         rtc_irq,            // Real-time clock interrupt line
   output logic              system_irq,         // Interrupt controller source 1
   output logic [15:0]       master_priority,    // Arbiter priority fields
   output logic              remapped            // Remap in effect
);

   // ****************************************************
   // Boot choice and decode
   // ****************************************************
   logic boot_rom;
   logic remap_r;

   // sample pin over last reset cycles
   bram_boot_sampler u_boot (
      .aclk               (aclk),
      .aresetn            (aresetn),
      .boot_source_select (boot_source_select),
      .boot_rom           (boot_rom)
   );

   bram_decoder u_dec (
      .req      (mst_req),
      .is_cpu   (mst_grant[0]),
      .remapped (remap_r),
      .boot_rom (boot_rom),
      .dec      (dec_out)
   );

   // vectors sit in the low area's first bytes
   assign vector_access = mst_req.valid && mst_req.addr < bram_pkg::VECTOR_BYTES;
   assign remapped      = remap_r;

   // ****************************************************
   // Abort broadcast
   // ****************************************************
   logic abort_now;

   // only the two fault causes abort
   assign abort_now = mst_req.valid && (dec_out.undefined || dec_out.misaligned);

   // every master sees it, owner acts
   assign mst_abort = {bram_pkg::NUM_MASTERS{abort_now}};

   // ****************************************************
   // Interrupt pass-through
   // ****************************************************
   // no mask, no status, straight through
   assign system_irq = ebi_refresh_irq | system_timer_irq | debug_serial_irq
                       | power_manager_irq | rtc_irq;

   // ****************************************************
   // AXI4-Lite write channel
   // ****************************************************
   logic        aw_held_r;
   logic [7:0]  aw_addr_r;
   logic        w_held_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        wr_go;

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready  = !w_held_r && !bvalid_r;
   assign wr_go         = aw_held_r && w_held_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;

   // Address and data taken in any order, held until both are in
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         else if (wr_go)
            aw_held_r <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         else if (wr_go)
            w_held_r <= 1'b0;
      end
   end

   // Response: OKAY on mapped writable words, SLVERR elsewhere
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= 2'b00;
      end
      else if (wr_go)
      begin
         bvalid_r <= 1'b1;
         bresp_r  <= (aw_addr_r == bram_pkg::OFF_REMAP_CONTROL ||
                      aw_addr_r == bram_pkg::OFF_MASTER_PRIORITY) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end

   // ****************************************************
   // Control registers
   // ****************************************************
   logic [15:0] mpr_r;

   // a one in the toggle bit flips remap
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         remap_r <= 1'b0;
      else if (wr_go && aw_addr_r == bram_pkg::OFF_REMAP_CONTROL && w_strb_r[0]
               && w_data_r[bram_pkg::RCR_TOGGLE_BIT])
         remap_r <= !remap_r;
   end

   // Priority fields per byte lane; reserved bits stay zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mpr_r <= bram_pkg::RST_MASTER_PRIORITY;
      else if (wr_go && aw_addr_r == bram_pkg::OFF_MASTER_PRIORITY)
      begin
         if (w_strb_r[0])
            mpr_r[7:0] <= w_data_r[7:0] & bram_pkg::MPR_WRITE_MASK[7:0];
         if (w_strb_r[1])
            mpr_r[15:8] <= w_data_r[15:8] & bram_pkg::MPR_WRITE_MASK[15:8];
      end
   end

   assign master_priority = mpr_r;

   // ****************************************************
   // AXI4-Lite read channel
   // ****************************************************
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        rd_go;
   logic        status_read;
   logic [31:0] rd_mux;
   bram_pkg::bram_abort_t abt_r;
   logic [31:0] abt_addr_r;

   assign s_axi_arready = !rvalid_r;
   assign rd_go         = s_axi_arvalid && s_axi_arready;
   assign status_read   = rd_go && s_axi_araddr == bram_pkg::OFF_ABORT_STATUS;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   // Read mux; control register is write-only and reads zero
   always_comb
   begin
      case (s_axi_araddr)
         bram_pkg::OFF_ABORT_STATUS:
            rd_mux = {4'h0, abt_r.sticky, 4'h0, abt_r.source, 4'h0, abt_r.kind,
                      abt_r.size, 6'h00, abt_r.misaligned, abt_r.undefined};
         bram_pkg::OFF_ABORT_ADDRESS:   rd_mux = abt_addr_r;
         bram_pkg::OFF_MASTER_PRIORITY: rd_mux = {16'h0000, mpr_r};
         default:                       rd_mux = 32'h0000_0000;
      endcase
   end

   // Data registered on the edge that takes the address, valid from the next cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= 2'b00;
      end
      else if (rd_go)
      begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= (s_axi_araddr == bram_pkg::OFF_ABORT_STATUS ||
                      s_axi_araddr == bram_pkg::OFF_ABORT_ADDRESS ||
                      s_axi_araddr == bram_pkg::OFF_MASTER_PRIORITY ||
                      s_axi_araddr == bram_pkg::OFF_REMAP_CONTROL) ? 2'b00 : 2'b10;
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end

   // ****************************************************
   // Abort capture
   // ****************************************************
   // full address of faulting access
   // cpu data abort keeps the data address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         abt_addr_r <= bram_pkg::RST_ABORT_ADDRESS;
      else if (abort_now)
         abt_addr_r <= mst_req.addr;
   end

   logic src_new_r; // Source abort not yet returned by a status read

   // sticky keeps unread aborts not shown in source
   // source bit index is master number
   // newest abort replaces the old one
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         abt_r.sticky     <= 4'h0;
         abt_r.source     <= 4'h0;
         abt_r.kind       <= bram_pkg::TY_READ;
         abt_r.size       <= bram_pkg::SZ_BYTE;
         abt_r.misaligned <= 1'b0;
         abt_r.undefined  <= 1'b0;
         src_new_r        <= 1'b0;
      end
      else if (abort_now)
      begin
         // An abort already returned by a read no longer counts as unread
         abt_r.sticky     <= status_read ? 4'h0 : (abt_r.sticky | (src_new_r ? abt_r.source : 4'h0));
         abt_r.source     <= mst_grant;
         abt_r.kind       <= mst_req.kind;
         abt_r.size       <= mst_req.size;
         abt_r.misaligned <= dec_out.misaligned;
         abt_r.undefined  <= dec_out.undefined;
         src_new_r        <= 1'b1;
      end
      else if (status_read)
      begin
         abt_r.sticky     <= 4'h0;
         src_new_r        <= 1'b0;
      end
   end

endmodule // bram_monitor

// ==== pkg/bram_pkg.sv ====
// Package: register map, field layout and types for the boot remap and abort monitor
package bram_pkg;

   // ****************************************************
   // Register offsets
   // ****************************************************
   localparam logic [7:0] OFF_REMAP_CONTROL   = 8'h00;
   localparam logic [7:0] OFF_ABORT_STATUS    = 8'h04;
   localparam logic [7:0] OFF_ABORT_ADDRESS   = 8'h08;
   localparam logic [7:0] OFF_MASTER_PRIORITY = 8'h0c;

   // ****************************************************
   // Reset values and field positions
   // ****************************************************
   localparam logic [31:0] RST_ABORT_STATUS    = 32'h0000_0000;
   localparam logic [31:0] RST_ABORT_ADDRESS   = 32'h0000_0000;
   localparam logic [15:0] RST_MASTER_PRIORITY = 16'h3210;
   localparam logic [15:0] MPR_WRITE_MASK      = 16'h7777;
   localparam int          RCR_TOGGLE_BIT      = 0;
   localparam int          NUM_MASTERS         = 4;
   localparam int          BOOT_SAMPLE_CYCLES  = 2;

   // ****************************************************
   // Address map
   // ****************************************************
   localparam logic [3:0]  AREA_INTERNAL = 4'h0;
   localparam logic [3:0]  AREA_CS_FIRST = 4'h1;
   localparam logic [3:0]  AREA_CS_LAST  = 4'h8;
   localparam logic [3:0]  AREA_PERIPH   = 4'hf;
   localparam logic [7:0]  SUB_AREA_LOW  = 8'h00;
   localparam logic [7:0]  SUB_AREA_ROM  = 8'h01;
   localparam logic [7:0]  SUB_AREA_SRAM = 8'h02;
   localparam logic [7:0]  SUB_AREA_LAST = 8'h03;
   localparam logic [31:0] VECTOR_BYTES  = 32'h0000_0020;

   // ****************************************************
   // Types
   // ****************************************************
   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_HALF = 2'b01,
      SZ_WORD = 2'b10,
      SZ_RSVD = 2'b11
   } bram_size_t;

   typedef enum logic [1:0] {
      TY_READ  = 2'b00,
      TY_WRITE = 2'b01,
      TY_FETCH = 2'b10,
      TY_RSVD  = 2'b11
   } bram_type_t;

   typedef enum logic [2:0] {
      TGT_ROM   = 3'b000,
      TGT_SRAM  = 3'b001,
      TGT_USB   = 3'b010,
      TGT_EXT   = 3'b011,
      TGT_PERIPH = 3'b100,
      TGT_NONE  = 3'b111
   } bram_target_t;

   // One master's request as seen by the decoder
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      bram_size_t  size;
      bram_type_t  kind;
   } bram_req_t;

   // Captured abort record
   typedef struct packed {
      logic [3:0]  sticky;
      logic [3:0]  source;
      bram_type_t  kind;
      bram_size_t  size;
      logic        misaligned;
      logic        undefined;
   } bram_abort_t;

   // Decode answer
   typedef struct packed {
      bram_target_t target;
      logic [2:0]   ext_cs;
      logic [31:0]  local_addr;
      logic         undefined;
      logic         misaligned;
   } bram_decode_t;

endpackage

// ==== core/bram_boot_sampler.sv ====
// Boot source sampler: catches the boot-select level over the last cycles of reset
`timescale 1ns/1ps
module bram_boot_sampler (
   input  wire logic aclk,               // System clock
   input  wire logic aresetn,            // Synchronous reset, active low
   input  wire logic boot_source_select, // Boot-select pin level
   output logic      boot_rom            // Latched choice: 1 = internal ROM
);

   logic       hist_r;    // Previous pin sample while in reset
   logic       boot_rom_r;

   // Shift in the pin while reset is held; both samples must agree on high
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hist_r <= boot_source_select;
      end
   end

   // Choice frozen at the release; pin is free for other use afterwards
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         boot_rom_r <= hist_r & boot_source_select;
      end
   end

   assign boot_rom = boot_rom_r;

endmodule // bram_boot_sampler

// ==== core/bram_decoder.sv ====
// Address decoder: remapped low area, undefined areas and alignment check
`timescale 1ns/1ps
module bram_decoder (
   input  bram_pkg::bram_req_t    req,      // Request from the granted master
   input  wire logic              is_cpu,   // Request comes from the processor
   input  wire logic              remapped, // Remap in effect
   input  wire logic              boot_rom, // Latched boot choice
   output bram_pkg::bram_decode_t dec       // Decode answer
);

   logic [3:0] area;
   logic [7:0] sub;

   assign area = req.addr[31:28];
   assign sub  = req.addr[27:20];

   // Target selection and fault checks
   always_comb
   begin
      dec            = '0;
      dec.target     = bram_pkg::TGT_NONE;
      dec.local_addr = {12'h000, req.addr[19:0]};
      if (area == bram_pkg::AREA_INTERNAL)
      begin
         case (sub)
            // SRAM in low area after remap
            bram_pkg::SUB_AREA_LOW:
            begin
               if (remapped)
                  dec.target = bram_pkg::TGT_SRAM;
               else if (boot_rom)
                  dec.target = bram_pkg::TGT_ROM;
               else
                  dec.target = bram_pkg::TGT_EXT;
            end
            bram_pkg::SUB_AREA_ROM:  dec.target = bram_pkg::TGT_ROM;
            bram_pkg::SUB_AREA_SRAM: dec.target = bram_pkg::TGT_SRAM;
            bram_pkg::SUB_AREA_LAST: dec.target = bram_pkg::TGT_USB;
            default:                 dec.undefined = 1'b1;
         endcase
      end
      else if (area >= bram_pkg::AREA_CS_FIRST && area <= bram_pkg::AREA_CS_LAST)
      begin
         dec.target     = bram_pkg::TGT_EXT;
         dec.ext_cs     = 3'(area - bram_pkg::AREA_CS_FIRST);
         dec.local_addr = {4'h0, req.addr[27:0]};
      end
      else if (area == bram_pkg::AREA_PERIPH)
      begin
         dec.target     = bram_pkg::TGT_PERIPH;
         dec.local_addr = {4'h0, req.addr[27:0]};
      end
      else
      begin
         dec.undefined = 1'b1;
      end
      if (!(is_cpu && req.kind == bram_pkg::TY_FETCH))
      begin
         if ((req.size == bram_pkg::SZ_WORD && req.addr[1:0] != 2'b00) ||
             (req.size == bram_pkg::SZ_HALF && req.addr[0]))
            dec.misaligned = 1'b1;
      end
      if (dec.undefined || dec.misaligned)
         dec.target = bram_pkg::TGT_NONE;
   end

endmodule // bram_decoder

// ==== dv/bram_master_model.sv ====
// Behavioural model of the four system bus masters
`timescale 1ns/1ps
module bram_master_model (
   input wire logic              aclk,      // System clock
   output bram_pkg::bram_req_t   mst_req,   // Request of granted master
   output logic [3:0]            mst_grant, // One-hot granted master
   input wire logic [3:0]        mst_abort, // Abort broadcast
   input bram_pkg::bram_decode_t dec_out    // Decode answer
);
   logic cpu_abt;
   logic usb_err;
   logic eth_abt;
   // Idle bus, processor granted
   initial
   begin
      mst_req = '0;
      mst_grant = 4'h1;
      cpu_abt = 1'b0;
      usb_err = 1'b0;
      eth_abt = 1'b0;
   end
   // One access; abort and decode taken at the sampling edge
   task automatic access(input int id, input logic [31:0] a, input logic [1:0] sz, input logic [1:0] ty,
                         output logic [3:0] ab, output bram_pkg::bram_decode_t d);
      @(posedge aclk);
      mst_grant <= 4'h1 << id;
      mst_req <= '{1'b1, a, bram_pkg::bram_size_t'(sz), bram_pkg::bram_type_t'(ty)};
      @(posedge aclk);
      ab = mst_abort;
      d = dec_out;
      if (ab[id] === 1'b1)
      begin
         case (id)
            0: cpu_abt = 1'b1;
            2: usb_err = 1'b1;
            3: eth_abt = 1'b1;
            default: ; // DMA ignores the abort
         endcase
      end
      // Released bus must not keep the old address
      mst_req <= '{1'b0, ~a, bram_pkg::bram_size_t'(sz), bram_pkg::bram_type_t'(ty)};
   endtask
endmodule // bram_master_model

// ==== dv/bram_monitor_assertions.sv ====
// Port-level assertions for the boot remap and abort monitor
`timescale 1ns/1ps
module bram_monitor_assertions (
   input wire logic              aclk,              // System clock
   input wire logic              aresetn,           // Reset, active low
   input bram_pkg::bram_req_t    mst_req,           // Master request
   input wire logic [3:0]        mst_grant,         // Granted master
   input wire logic [3:0]        mst_abort,         // Abort broadcast
   input bram_pkg::bram_decode_t dec_out,           // Decode answer
   input wire logic              vector_access,     // Vector area hit
   input wire logic              remapped,          // Remap state
   input wire logic              s_axi_bvalid,      // Write response
   input wire logic              system_irq,        // Source 1 out
   input wire logic              ebi_refresh_irq,   // Irq in
   input wire logic              system_timer_irq,  // Irq in
   input wire logic              debug_serial_irq,  // Irq in
   input wire logic              power_manager_irq, // Irq in
   input wire logic              rtc_irq            // Irq in
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Request decode helpers
   wire        v = mst_req.valid;
   wire [31:0] a = mst_req.addr;
   wire        fetch = mst_grant[0] && mst_req.kind == bram_pkg::TY_FETCH;
   wire        bad = (mst_req.size == bram_pkg::SZ_WORD && a[1:0] != 2'b00) || (mst_req.size == bram_pkg::SZ_HALF && a[0]);
   wire        low = v && a[31:20] == 12'h000;
   // ********
   // Checks
   // ********
   // Remap flips only as a write completes
   sequence s_flip;
      $changed(remapped);
   endsequence
   sequence s_resp;
      ##[0:1] $rose(s_axi_bvalid);
   endsequence
   AST_TOGGLE: assert property (s_flip |-> s_resp)
      else $error("remap changed without a write");
   AST_ABORT_ALL: assert property (mst_abort == {4{v && (dec_out.undefined || dec_out.misaligned)}})
      else $error("abort not broadcast");
   AST_MISALIGN: assert property (v && bad && !fetch |-> dec_out.misaligned && mst_abort == 4'hf)
      else $error("misaligned access not aborted");
   AST_FETCH: assert property (v && fetch && a[31:22] == 10'h000 |-> mst_abort == 4'h0)
      else $error("processor fetch aborted");
   AST_UNDEF: assert property (v && a[31:28] == 4'h0 && a[27:22] != 6'h00 |-> dec_out.undefined && mst_abort[0])
      else $error("undefined internal area not aborted");
   AST_GOOD: assert property (v && !bad && a[31:22] == 10'h000 |-> mst_abort == 4'h0)
      else $error("abort without cause");
   AST_REMAP_LOW: assert property (low && remapped |-> dec_out.target == bram_pkg::TGT_SRAM)
      else $error("low area not on SRAM");
   AST_BOOT_LOW: assert property (low && !remapped |-> dec_out.target == bram_pkg::TGT_ROM || dec_out.target == bram_pkg::TGT_EXT)
      else $error("low area not on boot memory");
   AST_CS0: assert property (v && a[31:28] == 4'h1 |-> dec_out.target == bram_pkg::TGT_EXT && dec_out.ext_cs == 3'h0)
      else $error("chip select zero area misdecoded");
   AST_VEC: assert property (vector_access == (v && a < 32'h0000_0020))
      else $error("vector flag wrong");
   AST_IRQ: assert property (system_irq == |{ebi_refresh_irq, system_timer_irq, debug_serial_irq, power_manager_irq, rtc_irq})
      else $error("system interrupt not the OR");
endmodule // bram_monitor_assertions

bind bram_monitor bram_monitor_assertions chk (.*);

// ==== dv/bram_monitor_bench.sv ====
// Self-checking bench for the boot remap and abort monitor
`timescale 1ns/1ps
module bram_monitor_bench;
   logic aclk, aresetn, boot_source_select, system_irq, remapped, vector_access;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic ebi_refresh_irq, system_timer_irq, debug_serial_irq, power_manager_irq, rtc_irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, mst_grant, mst_abort;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] master_priority;
   logic [4:0]  irqs;
   bram_pkg::bram_req_t    mst_req;
   bram_pkg::bram_decode_t dec_out;
   int failures, num_checks;
   assign {ebi_refresh_irq, system_timer_irq, debug_serial_irq, power_manager_irq, rtc_irq} = irqs;
   bram_monitor uut (.*);
   bram_master_model mdl (.aclk(aclk), .mst_req(mst_req), .mst_grant(mst_grant), .mst_abort(mst_abort), .dec_out(dec_out));
   // 40 MHz clock
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   // ********
   // Tasks
   // ********
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // AXI write; each channel dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // Waits for the answer; only the watchdog ends a hang
      do
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   // AXI read with expected data and response
   task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   // Master access; size 0 byte 1 half 2 word, type 0 read 1 write 2 fetch
   task automatic mst(input int id, input logic [31:0] a, input logic [1:0] sz, input logic [1:0] ty,
                      input logic [3:0] eab, input logic [2:0] et);
      logic [3:0] ab;
      bram_pkg::bram_decode_t d;
      mdl.access(id, a, sz, ty, ab, d);
      chk({28'h0, ab}, {28'h0, eab});
      if (eab == 4'h0) chk({29'h0, d.target}, {29'h0, et});
   endtask
   function automatic logic [31:0] st(input logic [3:0] sv, input logic [3:0] src, input logic [1:0] ty,
                                      input logic [1:0] sz, input logic mis, input logic und);
      return {4'h0, sv, 4'h0, src, 4'h0, ty, sz, 6'h00, mis, und};
   endfunction
   // Hang guard, far beyond the hundred or so cycles used
   initial
   begin
      repeat (5000) @(posedge aclk);
      failures++;
      print_verdict;
   end
   // ********
   // Tests
   // ********
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, irqs} = '0;
      s_axi_wstrb = 4'hf;
      boot_source_select = 1'b1;
      failures = 0;
      num_checks = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      boot_source_select <= 1'b0;
      // Reset contents and access kinds
      rdc(8'h04, 32'h0, 2'b00);
      rdc(8'h08, 32'h0, 2'b00);
      rdc(8'h0c, 32'h0000_3210, 2'b00);
      rdc(8'h40, 32'h0, 2'b10);
      wr(8'h04, 32'h1, 2'b10);
      wr(8'h40, 32'h1, 2'b10);
      wr(8'h0c, 32'hffff_ffff, 2'b00);
      rdc(8'h0c, 32'h0000_7777, 2'b00);
      chk({16'h0, master_priority}, 32'h0000_7777);
      $display("test registers done");
      // Boot memory, toggle and remapped SRAM
      mst(0, 32'h0000_0000, 2'd2, 2'd2, 4'h0, 3'd0);
      mst(1, 32'h0010_0000, 2'd2, 2'd0, 4'h0, 3'd0);
      wr(8'h00, 32'hffff_fffe, 2'b00);
      chk({31'h0, remapped}, 32'h0);
      wr(8'h00, 32'h1, 2'b00);
      chk({31'h0, remapped}, 32'h1);
      mst(0, 32'h0000_001c, 2'd2, 2'd2, 4'h0, 3'd1);
      mst(2, 32'h0020_0000, 2'd2, 2'd0, 4'h0, 3'd1);
      wr(8'h00, 32'h1, 2'b00);
      mst(3, 32'h0000_0004, 2'd2, 2'd0, 4'h0, 3'd0);
      mst(1, 32'h1000_0000, 2'd1, 2'd1, 4'h0, 3'd3);
      mst(2, 32'h0020_0003, 2'd0, 2'd1, 4'h0, 3'd1);
      $display("test remap done");
      // Aborts, capture and sticky flags
      mst(3, 32'h0020_0002, 2'd2, 2'd1, 4'hf, 3'd0);
      rdc(8'h08, 32'h0020_0002, 2'b00);
      mst(2, 32'h0040_0000, 2'd2, 2'd0, 4'hf, 3'd0);
      mst(1, 32'h9000_0000, 2'd1, 2'd0, 4'hf, 3'd0);
      rdc(8'h08, 32'h9000_0000, 2'b00);
      rdc(8'h04, st(4'hc, 4'h2, 2'd0, 2'd1, 1'b0, 1'b1), 2'b00);
      rdc(8'h04, st(4'h0, 4'h2, 2'd0, 2'd1, 1'b0, 1'b1), 2'b00);
      mst(0, 32'h0010_0001, 2'd2, 2'd2, 4'h0, 3'd0);
      mst(0, 32'h0020_0001, 2'd1, 2'd1, 4'hf, 3'd0);
      rdc(8'h08, 32'h0020_0001, 2'b00);
      mst(0, 32'h0050_0000, 2'd2, 2'd2, 4'hf, 3'd0);
      rdc(8'h04, st(4'h1, 4'h1, 2'd2, 2'd2, 1'b0, 1'b1), 2'b00);
      $display("test aborts done");
      // Interrupt pass-through, each line then none
      for (int i = 0; i < 6; i++)
      begin
         irqs <= (i < 5) ? 5'h01 << i : 5'h00;
         @(posedge aclk);
         @(posedge aclk);
         chk({31'h0, system_irq}, {31'h0, i < 5});
      end
      $display("test interrupt done");
      // Second reset; pin high only at the last reset edge
      wr(8'h00, 32'h1, 2'b00);
      aresetn <= 1'b0;
      @(posedge aclk);
      @(posedge aclk);
      boot_source_select <= 1'b1;
      @(posedge aclk);
      aresetn <= 1'b1;
      boot_source_select <= 1'b0;
      chk({31'h0, remapped}, 32'h0);
      rdc(8'h04, 32'h0, 2'b00);
      rdc(8'h08, 32'h0, 2'b00);
      mst(0, 32'h0000_0000, 2'd2, 2'd2, 4'h0, 3'd3);
      $display("test boot select done");
      print_verdict;
   end
endmodule // bram_monitor_bench
